// ---- bst_top.sv ----
// beam smoothing and cascade trigger block with apb register access
//
// Overview of operation
// - runs of interrupted beams below threshold ignored
// - inverted mode ignores short runs of free beams
// - smoothing threshold at bit 8 of config
// - inverted threshold at bit 0 of config
// - two-register write at 0x47 sets thresholds, echoed
// - function type 1 makes curtain trigger master
// - function type 0 slave waits for trigger
// - cascading works only when enabled on all
// - master trigger period is master cycle milliseconds
// - slave waits programmed microseconds before scanning
// - master pin uses output function code 3
// - switching code 0 means light switching polarity
// - slave pin uses input function code 1
`timescale 1ns/1ns
`default_nettype none
`include "bst_consts.svh"
module bst_top import bst_pkg::*; (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receiver beam states, 1 = interrupted
  input wire logic [`BST_NBEAM-1:0] beam_in,
  output logic [`BST_NBEAM-1:0] beam_out,
  output logic scan_busy,
  // cascade pin
  input wire logic trig_pin_in,
  output logic trig_pin_out,
  output logic trig_pin_oe
);
  logic [15:0] gen_r;
  logic casc_en_r;
  logic func_r;
  logic sw_r;
  logic [3:0] fcode_r;
  logic [15:0] mcyc_r;
  logic [15:0] dly_r;
  logic [31:0] mbdata_r;
  logic [31:0] mbecho_r;
  logic mberr_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [`BST_NBEAM-1:0] beam_s1_r;
  logic [`BST_NBEAM-1:0] beam_s2_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_d_r;
  bst_state_type state_r;
  bst_state_type state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] ms_cnt_r;
  logic [7:0] tw_cnt_r;
  logic trig_r;
  logic out_r;
  logic oe_r;
  logic busy_r;
  logic us_tick;
  logic ms_tick;
  logic wr_en;
  logic setup;
  logic master_on;
  logic slave_mode;
  logic trig_edge;
  logic scan_done;
  logic [`BST_NBEAM-1:0] beams_smoothed;

  // single decode used by write enable and error response
  function automatic logic reg_hit(input logic [7:0] a);
    case (a)
      `BST_OFF_GEN, `BST_OFF_CASC, `BST_OFF_MCYC, `BST_OFF_DLY, `BST_OFF_MBDATA,
      `BST_OFF_MBREQ, `BST_OFF_MBECHO, `BST_OFF_BEAMS, `BST_OFF_STAT: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready_r & pwrite & reg_hit(paddr);

  // zero wait state: answer is prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~reg_hit(paddr);
      if (setup && !pwrite) begin
        case (paddr)
          `BST_OFF_GEN: prdata_r <= {16'h0000, gen_r};
          `BST_OFF_CASC: prdata_r <= {4'h0, fcode_r, 7'h00, sw_r, 7'h00, func_r, 7'h00, casc_en_r};
          `BST_OFF_MCYC: prdata_r <= {16'h0000, mcyc_r};
          `BST_OFF_DLY: prdata_r <= {16'h0000, dly_r};
          `BST_OFF_MBDATA: prdata_r <= mbdata_r;
          `BST_OFF_MBECHO: prdata_r <= mbecho_r;
          `BST_OFF_BEAMS: prdata_r <= beam_out;
          `BST_OFF_STAT: prdata_r <= {27'h0000000, mberr_r, trig_r, oe_r, state_r};
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // thresholds: direct write or the two-register block write at 0x47
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_r <= `BST_GEN_RST;
      mbdata_r <= 32'h0000_0000;
      mbecho_r <= 32'h0000_0000;
      mberr_r <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        `BST_OFF_GEN: gen_r <= pwdata[15:0];
        `BST_OFF_MBDATA: mbdata_r <= pwdata;
        `BST_OFF_MBREQ: begin
          if (pwdata == {`BST_MB_SMOOTH_ADDR, `BST_MB_SMOOTH_CNT}) begin
            gen_r <= mbdata_r[15:0];
            mbecho_r <= pwdata;
            mberr_r <= 1'b0;
          end else begin
            mbecho_r <= 32'h0000_0000;
            mberr_r <= 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      casc_en_r <= 1'b0;
      func_r <= `BST_FUNC_SLAVE;
      sw_r <= `BST_SW_LIGHT;
      fcode_r <= 4'h0;
      mcyc_r <= `BST_MCYC_RST;
      dly_r <= `BST_DLY_RST;
    end else if (wr_en) begin
      case (paddr)
        `BST_OFF_CASC: begin
          casc_en_r <= pwdata[`BST_CASC_EN_BIT];
          func_r <= pwdata[`BST_CASC_FUNC_BIT];
          sw_r <= pwdata[`BST_CASC_SW_BIT];
          fcode_r <= pwdata[`BST_CASC_FC_LSB +: 4];
        end
        `BST_OFF_MCYC: mcyc_r <= pwdata[15:0];
        `BST_OFF_DLY: dly_r <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      beam_s1_r <= '0;
      beam_s2_r <= '0;
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_d_r <= 1'b0;
    end else begin
      beam_s1_r <= beam_in;
      beam_s2_r <= beam_s1_r;
      pin_s1_r <= trig_pin_in;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  assign master_on = casc_en_r & (func_r == `BST_FUNC_MASTER) & (fcode_r == `BST_FC_TRIG_OUT);
  assign slave_mode = casc_en_r & (func_r == `BST_FUNC_SLAVE);
  // active edge follows switching polarity: light switching is rising
  assign trig_edge = slave_mode && fcode_r == `BST_FC_TRIG_IN
    && ((pin_s2_r ^ sw_r) & ~(pin_d_r ^ sw_r));
  assign scan_done = state_r == BST_SCAN && us_tick && cnt_r == 16'(`BST_SCAN_US - 1);

  bst_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .us_tick(us_tick),
    .ms_tick(ms_tick)
  );

  bst_smooth u_smooth (
    .pclk(pclk),
    .presetn(presetn),
    .load(scan_done),
    .beams(beam_s2_r),
    .smooth_thr(gen_r[`BST_GEN_SMOOTH_LSB +: 8]),
    .inv_thr(gen_r[`BST_GEN_INV_LSB +: 8]),
    .result(beams_smoothed)
  );

  assign beam_out = beams_smoothed;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BST_IDLE: begin
        if (!slave_mode) begin
          state_nxt = BST_SCAN;
        end else if (trig_edge) begin
          state_nxt = BST_DELAY;
        end
      end
      BST_DELAY: begin
        if (us_tick && cnt_r == dly_r) begin
          state_nxt = BST_SCAN;
        end
      end
      BST_SCAN: begin
        if (scan_done) begin
          state_nxt = BST_IDLE;
        end
      end
      default: state_nxt = BST_IDLE;
    endcase
  end

  // one counter serves delay and scan; edges during either are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= BST_IDLE;
      cnt_r <= 16'h0000;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= state_nxt == BST_SCAN;
      if (state_nxt != state_r) begin
        cnt_r <= 16'h0000;
      end else if (us_tick && state_r != BST_IDLE) begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

  assign scan_busy = busy_r;

  // master period counted in millisecond enables; zero acts as one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_r <= 16'h0000;
      trig_r <= 1'b0;
      tw_cnt_r <= 8'h00;
    end else if (!master_on) begin
      ms_cnt_r <= 16'h0000;
      trig_r <= 1'b0;
      tw_cnt_r <= 8'h00;
    end else begin
      if (ms_tick) begin
        if (ms_cnt_r + 16'h0001 >= mcyc_r) begin
          ms_cnt_r <= 16'h0000;
          trig_r <= 1'b1;
          tw_cnt_r <= 8'h00;
        end else begin
          ms_cnt_r <= ms_cnt_r + 16'h0001;
        end
      end else if (trig_r && us_tick) begin
        if (tw_cnt_r == 8'(`BST_TRIG_US - 1)) begin
          trig_r <= 1'b0;
        end else begin
          tw_cnt_r <= tw_cnt_r + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      oe_r <= master_on;
      out_r <= master_on & (trig_r ^ sw_r);
    end
  end

  assign trig_pin_out = out_r;
  assign trig_pin_oe = oe_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_GEN_WRITE: assert property (wr_en && paddr == `BST_OFF_GEN |=>
    gen_r[15:8] == $past(pwdata[15:8]) && gen_r[7:0] == $past(pwdata[7:0]))
    else $error("threshold fields not stored");
  AST_MB_WRITE: assert property (wr_en && paddr == `BST_OFF_MBREQ
    && pwdata == 32'h0047_0002 |=> gen_r == $past(mbdata_r[15:0])
    && mbecho_r == 32'h0047_0002 && !mberr_r)
    else $error("block write at 0x47 not applied");
  AST_MASTER_ONLY_DRIVES: assert property (trig_pin_oe |-> $past(master_on))
    else $error("pin driven outside master mode");
  AST_OE_NEEDS_CODE3: assert property ($rose(trig_pin_oe) |->
    $past(fcode_r) == 4'h3 && $past(casc_en_r))
    else $error("pin driven without function code 3");
  AST_SLAVE_WAITS: assert property (slave_mode && state_r == BST_IDLE && !trig_edge
    |=> state_r == BST_IDLE)
    else $error("slave started without trigger");
  AST_DISABLED_NO_PIN: assert property (!casc_en_r ##1 !casc_en_r |->
    !trig_pin_oe && !trig_r) else $error("cascade active while disabled");
  AST_PERIOD: assert property ($rose(trig_r) |->
    $past(ms_tick) && $past(ms_cnt_r) + 16'h0001 >= $past(mcyc_r))
    else $error("trigger before period elapsed");
  AST_DELAY_LEN: assert property (state_r == BST_DELAY && state_nxt == BST_SCAN |->
    cnt_r >= dly_r) else $error("scan started before delay");
  AST_POLARITY: assert property (master_on && sw_r == 1'b0 && !trig_r |=>
    !trig_pin_out) else $error("light switching polarity broken");
  AST_NEEDS_CODE1: assert property (slave_mode && fcode_r != 4'h1
    && state_r == BST_IDLE |=> state_r == BST_IDLE)
    else $error("trigger accepted without input code 1");
  AST_BUSY_IGNORES: assert property (state_r == BST_SCAN && trig_edge && !scan_done
    |=> state_r == BST_SCAN)
    else $error("trigger not ignored while busy");
  COV_MASTER_TRIG: cover property ($rose(trig_r));
  COV_SLAVE_SCAN: cover property (state_r == BST_DELAY ##[1:1000] state_r == BST_SCAN);
  COV_MB_ERR: cover property ($rose(mberr_r));
  COV_FREE_SCAN: cover property (!casc_en_r && scan_done);
endmodule // bst_top
`default_nettype wire

// ---- bst_consts.svh ----
// constants for the beam smoothing and cascade trigger block
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH
`define BST_NBEAM 32
`define BST_CLK_MHZ 25
`define BST_US_CYC (`BST_CLK_MHZ)
`define BST_MS_US 1000
`define BST_SCAN_US 50
`define BST_TRIG_US 10
`define BST_OFF_GEN 8'h00
`define BST_OFF_CASC 8'h04
`define BST_OFF_MCYC 8'h08
`define BST_OFF_DLY 8'h0C
`define BST_OFF_MBDATA 8'h10
`define BST_OFF_MBREQ 8'h14
`define BST_OFF_MBECHO 8'h18
`define BST_OFF_BEAMS 8'h1C
`define BST_OFF_STAT 8'h20
`define BST_GEN_SMOOTH_LSB 8
`define BST_GEN_INV_LSB 0
`define BST_CASC_EN_BIT 0
`define BST_CASC_FUNC_BIT 8
`define BST_CASC_SW_BIT 16
`define BST_CASC_FC_LSB 24
`define BST_FUNC_MASTER 1'b1
`define BST_FUNC_SLAVE 1'b0
`define BST_FC_TRIG_IN 4'h1
`define BST_FC_TRIG_OUT 4'h3
`define BST_SW_LIGHT 1'b0
`define BST_MB_SMOOTH_ADDR 16'h0047
`define BST_MB_SMOOTH_CNT 16'h0002
`define BST_GEN_RST 16'h0000
`define BST_MCYC_RST 16'h000A
`define BST_DLY_RST 16'h0000
`endif

// ---- bst_pkg.sv ----
// types shared by the beam smoothing and cascade trigger block
`default_nettype none
package bst_pkg;
  typedef enum logic [1:0] {
    BST_IDLE,
    BST_DELAY,
    BST_SCAN
  } bst_state_type;
endpackage
`default_nettype wire

// ---- bst_tick.sv ----
// microsecond and millisecond enable pulses from the system clock
`timescale 1ns/1ns
`default_nettype none
`include "bst_consts.svh"
module bst_tick import bst_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // enables
  output logic us_tick,
  output logic ms_tick
);
  logic [4:0] us_div_r;
  logic [9:0] ms_div_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      us_div_r <= 5'h00;
      us_tick <= 1'b0;
    end else if (us_div_r == 5'(`BST_US_CYC - 1)) begin
      us_div_r <= 5'h00;
      us_tick <= 1'b1;
    end else begin
      us_div_r <= us_div_r + 5'h01;
      us_tick <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_div_r <= 10'h000;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= 1'b0;
      if (us_tick) begin
        if (ms_div_r == 10'(`BST_MS_US - 1)) begin
          ms_div_r <= 10'h000;
          ms_tick <= 1'b1;
        end else begin
          ms_div_r <= ms_div_r + 10'h001;
        end
      end
    end
  end
endmodule // bst_tick
`default_nettype wire

// ---- bst_smooth.sv ----
// beam smoothing: drops short runs of interrupted, then of free beams
`timescale 1ns/1ns
`default_nettype none
`include "bst_consts.svh"
module bst_smooth import bst_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // evaluation
  input wire logic load,
  input wire logic [`BST_NBEAM-1:0] beams,
  input wire logic [7:0] smooth_thr,
  input wire logic [7:0] inv_thr,
  output logic [`BST_NBEAM-1:0] result
);
  localparam int N = `BST_NBEAM;

  // clears every run of ones shorter than thr; thr 0 or 1 passes all
  function automatic logic [N-1:0] drop_short(input logic [N-1:0] b, input logic [7:0] thr);
    logic [N-1:0] o;
    int run;
    o = b;
    run = 0;
    for (int i = 0; i <= N; i++) begin
      if (i < N && b[i]) begin
        run = run + 1;
      end else begin
        if (run > 0 && run < int'(thr)) begin
          for (int j = 0; j < N; j++) begin
            if (j >= i - run && j < i) begin
              o[j] = 1'b0;
            end
          end
        end
        run = 0;
      end
    end
    return o;
  endfunction

  logic [N-1:0] stage1;
  logic [N-1:0] stage2;

  always_comb begin
    stage1 = drop_short(beams, smooth_thr);
    stage2 = ~drop_short(~stage1, inv_thr);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= '0;
    end else if (load) begin
      result <= stage2;
    end
  end

  // an isolated interrupted beam in the interior never survives threshold 2
  AST_SMOOTH_NO_SINGLE: assert property (@(posedge pclk) disable iff (!presetn)
    load && smooth_thr >= 8'h02 && inv_thr <= 8'h01 |=>
      ((result & ~(result << 1) & ~(result >> 1)) & {1'b0, {(N-2){1'b1}}, 1'b0}) == '0)
    else $error("single interrupted beam passed smoothing");
  AST_INV_NO_SINGLE: assert property (@(posedge pclk) disable iff (!presetn)
    load && inv_thr >= 8'h02 && smooth_thr <= 8'h01 |=>
      ((~result & (result << 1) & (result >> 1)) & {1'b0, {(N-2){1'b1}}, 1'b0}) == '0)
    else $error("single free beam passed inverted smoothing");
endmodule // bst_smooth
`default_nettype wire

// ---- bst_peer.sv ----
// partner model: another light curtain on the shared cascade trigger line
`timescale 1ns/1ns
`default_nettype none
module bst_peer (
  // clock and bench control
  input wire logic pclk,
  input wire logic act_master,
  input wire logic fire,
  // cascade line
  input wire logic dut_out,
  input wire logic dut_oe,
  output logic line,
  // pulses seen while the block is master
  output var int rise_cnt,
  output var int period,
  output var int width
);
  int pulse = 0;
  int cnt = 0;
  int t_rise = 0;
  logic prev = 1'b0;
  logic flt = 1'b0;
  // high pulse of 10 us, low in between: light switching
  always_ff @(posedge pclk) pulse <= fire ? 250 : (pulse > 0 ? pulse - 1 : 0);
  // an undriven line keeps no stale level, it toggles every cycle
  always_ff @(posedge pclk) flt <= ~line;
  // as master the peer has cascading on and drives the line whenever the block does not
  assign line = dut_oe ? dut_out : (act_master ? (pulse > 0) : flt);
  always_ff @(posedge pclk) begin
    cnt <= cnt + 1;
    prev <= dut_oe & dut_out;
    if (dut_oe & dut_out & ~prev) begin
      rise_cnt <= rise_cnt + 1;
      period <= cnt - t_rise;
      t_rise <= cnt;
    end
    if (~(dut_oe & dut_out) & prev) width <= cnt - t_rise;
  end
endmodule // bst_peer
`default_nettype wire

// ---- tb_bst_top.sv ----
// self-checking bench for the beam smoothing and cascade trigger block
`timescale 1ns/1ns
`default_nettype none
`include "bst_consts.svh"
module tb_bst_top import bst_pkg::*;;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} bst_tb_exp_type;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] beam_in = 32'h0;
  logic pm_master = 1'b0;
  logic pm_fire = 1'b0;
  logic [31:0] prdata, beam_out, rnd, gen_now;
  logic pready, pslverr, scan_busy, trig_line, trig_pin_out, trig_pin_oe;
  int rise_cnt, period, width, n;
  int err_total = 0;
  int check_count = 0;
  bst_tb_exp_type exp_q[$];
  logic [31:0] mb_ok = {`BST_MB_SMOOTH_ADDR, `BST_MB_SMOOTH_CNT};
  logic [7:0] ra[6] = '{`BST_OFF_GEN, `BST_OFF_CASC, `BST_OFF_MCYC, `BST_OFF_DLY,
    `BST_OFF_MBECHO, 8'h24};
  logic [31:0] rv[6] = '{32'h0, 32'h0, {16'h0, `BST_MCYC_RST}, 32'h0, 32'h0, 32'h0};

  bst_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .beam_in(beam_in), .beam_out(beam_out), .scan_busy(scan_busy),
    .trig_pin_in(trig_line), .trig_pin_out(trig_pin_out), .trig_pin_oe(trig_pin_oe));
  bst_peer peer_u (.pclk(pclk), .act_master(pm_master), .fire(pm_fire),
    .dut_out(trig_pin_out), .dut_oe(trig_pin_oe), .line(trig_line), .rise_cnt(rise_cnt),
    .period(period), .width(width));

  initial begin
    forever #20 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic bad(input string s);
    err_total++;
    $display("[FAIL] %0t %s", $time, s);
  endtask

  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e, input string s);
    check_count++;
    if (g !== e) bad(s);
  endtask

  task automatic cmp_bit(input logic g, input logic e, input string s);
    check_count++;
    if (g !== e) bad(s);
  endtask

  task automatic cmp_num(input int g, input int lo, input int hi, input string s);
    check_count++;
    if (g < lo || g > hi) bad(s);
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // turns runs of value v shorter than t into the opposite value
  function automatic logic [31:0] runs(input logic [31:0] b, input logic v, input int t);
    int s;
    logic [31:0] r;
    r = b;
    s = 0;
    for (int k = 0; k <= 32; k++) begin
      if (k == 32 || b[k] !== v) begin
        if (k - s < t) for (int j = s; j < k; j++) r[j] = ~v;
        s = k + 1;
      end
    end
    return r;
  endfunction

  // reads and writes alike note what the monitor must see
  always @(posedge pclk) begin
    bst_tb_exp_type x;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (exp_q.size() == 0) bad("stray transfer");
      else begin
        x = exp_q.pop_front();
        cmp_word(prdata & x.m, x.d & x.m, "read data");
        cmp_bit(pslverr, x.e, "slave error");
      end
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] m, input logic e);
    int k;
    exp_q.push_back('{d, m, e});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (pready !== 1'b1) begin
      bad("no ready");
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_busy(input logic v, input int lim);
    n = 0;
    while (scan_busy !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (scan_busy !== v) begin
      bad("scan wait");
      report_and_stop();
    end
  endtask

  task automatic stay_idle(input int cyc, input string s);
    repeat (cyc) begin
      @(posedge pclk);
      cmp_bit(scan_busy, 1'b0, s);
    end
  endtask

  task automatic smooth_case(input logic [31:0] b, input logic [7:0] s,
      input logic [7:0] i, input logic mb);
    logic [31:0] ex;
    ex = runs(runs(b, 1'b1, s), 1'b0, i);
    gen_now = {16'h0, s, i};
    beam_in <= b;
    if (mb) begin
      apb(1'b1, `BST_OFF_MBDATA, gen_now, 32'h0, 1'b0);
      apb(1'b1, `BST_OFF_MBREQ, mb_ok, 32'h0, 1'b0);
      apb(1'b0, `BST_OFF_MBECHO, mb_ok, 32'hFFFFFFFF, 1'b0);
    end else begin
      apb(1'b1, `BST_OFF_GEN, gen_now, 32'h0, 1'b0);
    end
    apb(1'b0, `BST_OFF_GEN, gen_now, 32'h0000FFFF, 1'b0);
    // two whole scans of 50 us so that the new beams and thresholds are used
    repeat (2700) @(posedge pclk);
    cmp_word(beam_out, ex, "smoothed beams");
    apb(1'b0, `BST_OFF_BEAMS, ex, 32'hFFFFFFFF, 1'b0);
  endtask

  initial begin
    int n0;
    rnd = 32'h8405;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[k]) apb(1'b0, ra[k], rv[k], 32'hFFFFFFFF, ra[k] == 8'h24);
    apb(1'b1, 8'h24, 32'hFFFFFFFF, 32'h0, 1'b1);
    smooth_case(32'h00F0_7000, 8'h04, 8'h00, 1'b0);
    smooth_case(32'h07B1_E8F0, 8'h00, 8'h04, 1'b1);
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      smooth_case(rnd & 32'h0FFF_FFF0, {5'h0, rnd[10:8]}, {6'h0, rnd[1:0]} + {7'h0, rnd[2]},
        k[0]);
    end
    apb(1'b1, `BST_OFF_MBREQ, 32'h0048_0002, 32'h0, 1'b0);
    apb(1'b0, `BST_OFF_STAT, 32'h10, 32'h10, 1'b0);
    apb(1'b0, `BST_OFF_MBECHO, 32'h0, 32'hFFFFFFFF, 1'b0);
    apb(1'b0, `BST_OFF_GEN, gen_now, 32'h0000FFFF, 1'b0);
    apb(1'b1, `BST_OFF_MCYC, 32'h1, 32'h0, 1'b0);
    apb(1'b1, `BST_OFF_CASC, 32'h0300_0101, 32'h0, 1'b0);
    n0 = rise_cnt;
    n = 0;
    while (rise_cnt < n0 + 2 && n < 60000) begin
      @(posedge pclk);
      n++;
    end
    cmp_num(rise_cnt - n0, 2, 2, "no trigger");
    if (rise_cnt < n0 + 2) report_and_stop();
    cmp_bit(trig_pin_oe, 1'b1, "pin drive");
    cmp_num(period, 25000, 25000, "trigger period");
    repeat (300) @(posedge pclk);
    cmp_num(width, 245, 255, "pulse width");
    cmp_bit(trig_pin_out, 1'b0, "idle level");
    apb(1'b1, `BST_OFF_CASC, 32'h0301_0101, 32'h0, 1'b0);
    repeat (4) @(posedge pclk);
    cmp_bit(trig_pin_out, 1'b1, "inverted idle level");
    apb(1'b1, `BST_OFF_CASC, 32'h0300_0100, 32'h0, 1'b0);
    repeat (4) @(posedge pclk);
    cmp_bit(trig_pin_oe, 1'b0, "drive off");
    pm_master <= 1'b1;
    apb(1'b1, `BST_OFF_DLY, 32'h14, 32'h0, 1'b0);
    // slave without the input pin code must ignore the line entirely
    apb(1'b1, `BST_OFF_CASC, 32'h0000_0001, 32'h0, 1'b0);
    wait_busy(1'b0, 1400);
    pm_fire <= 1'b1;
    @(posedge pclk);
    pm_fire <= 1'b0;
    stay_idle(1000, "no input code");
    apb(1'b1, `BST_OFF_CASC, 32'h0100_0001, 32'h0, 1'b0);
    repeat (4) @(posedge pclk);
    cmp_bit(trig_pin_oe, 1'b0, "slave drive");
    wait_busy(1'b0, 1400);
    stay_idle(2000, "free scan");
    pm_fire <= 1'b1;
    @(posedge pclk);
    pm_fire <= 1'b0;
    wait_busy(1'b1, 600);
    cmp_num(n, 503, 535, "trigger delay");
    repeat (300) @(posedge pclk);
    pm_fire <= 1'b1;
    @(posedge pclk);
    pm_fire <= 1'b0;
    wait_busy(1'b0, 1400);
    stay_idle(1000, "retrigger");
    apb(1'b1, `BST_OFF_CASC, 32'h0100_0000, 32'h0, 1'b0);
    wait_busy(1'b1, 1400);
    cmp_bit(scan_busy, 1'b1, "off free scan");
    if (exp_q.size() != 0) bad("missing transfer");
    report_and_stop();
  end
endmodule // tb_bst_top
`default_nettype wire
